// ---- inc/frs_pkg.sv ----
// package: result status byte layouts, offsets and codes
package frs_pkg;

    // data register offset (result bytes are read here)
    localparam logic [2:0] FRS_DATA_OFS      = 3'h5;

    // interrupt cause codes
    localparam logic [1:0] FRS_IC_NORMAL     = 2'h0;
    localparam logic [1:0] FRS_IC_ABNORMAL   = 2'h1;
    localparam logic [1:0] FRS_IC_INVALID    = 2'h2;
    localparam logic [1:0] FRS_IC_POLL       = 2'h3;

    // bad track marker recorded on the medium
    localparam logic [7:0] FRS_BAD_TRACK_NUM = 8'hFF;

    // number of distinct result bytes built here (bytes 0 to 3)
    localparam int         FRS_NUM_BYTES     = 4;

    // result set kinds
    typedef enum logic [1:0] {
        FRS_SET_NONE  = 2'b00,  // no result phase
        FRS_SET_ST0   = 2'b01,  // byte 0 only
        FRS_SET_ST012 = 2'b10,  // bytes 0, 1, 2
        FRS_SET_ST3   = 2'b11   // byte 3 only
    } frs_set_t;

    // execution outcome events from the controller core
    typedef struct packed {
        logic       seek_end;       // seek, relative seek, recalibrate done
        logic       recal;          // command was recalibrate
        logic       track0_seen;    // track zero reached during recalibrate
        logic [1:0] cause;          // interrupt cause
        logic       write_cmd;      // write or format command
        logic       no_addr_mark;   // missing address mark
        logic       mark_in_data;   // mark missing after address field
        logic       sector_missing; // sector not found, marks present
        logic       late_service;   // overrun or underrun
        logic       crc_err;        // crc error seen
        logic       crc_in_data;    // crc error lay in data field
        logic       eot_no_tc;      // end of track without terminal count
        logic [7:0] found_track;    // track number read from the medium
        logic [7:0] cmd_track;      // track address in the command
        logic       track_mismatch; // recorded track differs
        logic       scan_cmd;       // command is a scan
        logic       scan_fail;      // host byte met no condition
        logic       scan_hit;       // equal byte found
        logic       control_mark;   // unexpected data mark kind
    } frs_exec_t;

    // drive line snapshot
    typedef struct packed {
        logic [1:0] drive;          // logical drive selected
        logic       head;           // head side select line level
    } frs_sel_t;

endpackage : frs_pkg

// ---- rtl/frs_result_status.sv ----
// result phase status bytes read back through the data register
`timescale 1ns/10ps
module frs_result_status
    import frs_pkg::*;
#(
    parameter int NUM_BYTES = FRS_NUM_BYTES
) (
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    // host read port
    input  wire logic [2:0] addr_i,
    input  wire logic       rd_i,
    // controller core
    input  wire logic       cmd_end_i,      // command phase ends
    input  wire frs_sel_t   cmd_sel_i,
    input  wire logic       exec_end_i,     // execution phase ends
    input  wire frs_sel_t   exec_sel_i,
    input  wire frs_exec_t  exec_i,
    input  wire frs_set_t   set_i,
    // drive lines
    input  wire logic       track_zero_line_i,
    input  wire logic       write_prot_b_i,
    // outputs
    output logic [7:0]      rd_data_o,
    output logic            result_phase_o,
    output logic            result_done_o
);

    if (NUM_BYTES != FRS_NUM_BYTES) begin : g_num_bytes_check
        $error("NUM_BYTES must be 4");
    end

    ////////////////////////////////////////////////////////////////////
    // byte assembly

    wire logic wp_active = ~write_prot_b_i;
    wire logic mark_miss = exec_i.no_addr_mark;
    wire logic bad_track = exec_i.sector_missing &&
                           exec_i.found_track == FRS_BAD_TRACK_NUM &&
                           exec_i.found_track != exec_i.cmd_track;

    wire logic [7:0] st0_next = {
        exec_i.cause,
        exec_i.seek_end,
        exec_i.recal & ~exec_i.track0_seen,
        1'b0,
        exec_sel_i.head,
        exec_sel_i.drive};

    wire logic [7:0] st1_next = {
        exec_i.eot_no_tc,
        1'b0,
        exec_i.crc_err,
        exec_i.late_service,
        1'b0,
        exec_i.sector_missing,
        exec_i.write_cmd & wp_active,
        mark_miss};

    wire logic [7:0] st2_next = {
        1'b0,
        exec_i.control_mark,
        exec_i.crc_err & exec_i.crc_in_data,
        exec_i.sector_missing & exec_i.track_mismatch,
        exec_i.scan_cmd & exec_i.scan_hit,
        exec_i.scan_cmd & exec_i.scan_fail,
        bad_track,
        mark_miss & exec_i.mark_in_data};

    ////////////////////////////////////////////////////////////////////
    // captured state

    logic [7:0] st0_reg;
    logic [7:0] st1_reg;
    logic [7:0] st2_reg;
    frs_sel_t   cmd_sel_reg;
    frs_set_t   set_reg;
    logic [1:0] idx_reg;
    logic       phase_reg;

    // live byte 3: command-phase selection plus drive lines
    wire logic [7:0] st3_live = {
        1'b0,
        wp_active,
        1'b1,
        track_zero_line_i,
        1'b1,
        cmd_sel_reg.head,
        cmd_sel_reg.drive};

    wire logic rd_take  = phase_reg && rd_i && addr_i == FRS_DATA_OFS;
    wire logic last_byt = (set_reg != FRS_SET_ST012) || idx_reg == 2'h2;
    wire logic start    = exec_end_i && set_i != FRS_SET_NONE;

    logic [7:0] sel_byte;
    always_comb begin
        unique case (set_reg)
            FRS_SET_ST3:   sel_byte = st3_live;
            FRS_SET_ST012: sel_byte = (idx_reg == 2'h0) ? st0_reg :
                                      (idx_reg == 2'h1) ? st1_reg : st2_reg;
            default:       sel_byte = st0_reg;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_sel_reg <= '0;
        end else if (cmd_end_i) begin
            cmd_sel_reg <= cmd_sel_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st0_reg <= 8'h00;
            st1_reg <= 8'h00;
            st2_reg <= 8'h00;
            set_reg <= FRS_SET_NONE;
        end else if (start) begin
            st0_reg <= st0_next;
            st1_reg <= st1_next;
            st2_reg <= st2_next;
            set_reg <= set_i;
        end
    end

    // result phase sequencing
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_reg <= 1'b0;
            idx_reg   <= 2'h0;
        end else if (start) begin
            phase_reg <= 1'b1;
            idx_reg   <= 2'h0;
        end else if (rd_take) begin
            phase_reg <= ~last_byt;
            idx_reg   <= idx_reg + 2'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_o     <= 8'h00;
            result_done_o <= 1'b0;
        end else begin
            rd_data_o     <= rd_take ? sel_byte : 8'h00;
            result_done_o <= rd_take && last_byt;
        end
    end

    assign result_phase_o = phase_reg;

    ////////////////////////////////////////////////////////////////////
    // checks

    a_outside_phase_zero: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        !rd_take |=> rd_data_o == 8'h00)
        else $error("read data not zero outside result phase");

    a_st0_fixed_bit: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        rd_take && set_reg != FRS_SET_ST3 && idx_reg == 2'h0
        |=> rd_data_o[3] == 1'b0)
        else $error("byte 0 bit 3 not zero");

    a_st3_fixed_bits: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        rd_take && set_reg == FRS_SET_ST3
        |=> rd_data_o[5] && rd_data_o[3] && !rd_data_o[7])
        else $error("byte 3 fixed bits wrong");

    a_st3_drive_lines: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        rd_take && set_reg == FRS_SET_ST3
        |=> rd_data_o[4] == $past(track_zero_line_i)
            && rd_data_o[6] == !$past(write_prot_b_i))
        else $error("byte 3 drive lines wrong");

    a_st3_selection: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        rd_take && set_reg == FRS_SET_ST3
        |=> rd_data_o[2:0] == {$past(cmd_sel_reg.head),
                               $past(cmd_sel_reg.drive)})
        else $error("byte 3 selection wrong");

    a_capture_cause: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start |=> st0_reg[7:6] == $past(exec_i.cause)
                  && st0_reg[2:0] == {$past(exec_sel_i.head),
                                      $past(exec_sel_i.drive)})
        else $error("byte 0 cause or selection wrong");

    a_three_byte_end: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start && set_i == FRS_SET_ST012 ##1 rd_take [*3]
        |=> !phase_reg && result_done_o)
        else $error("three byte set did not end");

    a_bad_track_flag: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start |=> st2_reg[1] == ($past(exec_i.sector_missing)
            && $past(exec_i.found_track) == 8'hFF
            && $past(exec_i.cmd_track) != 8'hFF))
        else $error("bad track flag wrong");

    ////////////////////////////////////////////////////////////////////
    // field capture and read path checks

    a_st0_drive: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> st0_reg[1:0] == $past(exec_sel_i.drive))
        else $error("byte 0 drive field wrong");

    a_st0_head: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> st0_reg[2] == $past(exec_sel_i.head))
        else $error("byte 0 head bit wrong");

    a_equip_check: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> st0_reg[4] == ($past(exec_i.recal)
            && !$past(exec_i.track0_seen)))
        else $error("byte 0 equipment check wrong");

    a_seek_end: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> st0_reg[5] == $past(exec_i.seek_end))
        else $error("byte 0 seek end wrong");

    a_zero_bits: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> !st0_reg[3] && !st1_reg[3] && !st1_reg[6] && !st2_reg[7])
        else $error("fixed zero bit set");

    a_mark_missing: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> st1_reg[0] == $past(exec_i.no_addr_mark))
        else $error("byte 1 missing mark wrong");

    a_write_protect: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> st1_reg[1] == ($past(exec_i.write_cmd)
            && !$past(write_prot_b_i)))
        else $error("byte 1 write protect wrong");

    a_missing_data: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> st1_reg[2] == $past(exec_i.sector_missing))
        else $error("byte 1 missing data wrong");

    a_late_service: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> st1_reg[4] == $past(exec_i.late_service))
        else $error("byte 1 overrun bit wrong");

    a_crc_error: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> st1_reg[5] == $past(exec_i.crc_err))
        else $error("byte 1 crc bit wrong");

    a_end_of_track: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> st1_reg[7] == $past(exec_i.eot_no_tc))
        else $error("byte 1 end of track wrong");

    a_mark_location: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> st2_reg[0] == ($past(exec_i.no_addr_mark)
            && $past(exec_i.mark_in_data)))
        else $error("byte 2 mark location wrong");

    a_scan_fail: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> st2_reg[2] == ($past(exec_i.scan_cmd)
            && $past(exec_i.scan_fail)))
        else $error("byte 2 scan not satisfied wrong");

    a_scan_hit: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> st2_reg[3] == ($past(exec_i.scan_cmd)
            && $past(exec_i.scan_hit)))
        else $error("byte 2 scan satisfied wrong");

    a_wrong_track: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> st2_reg[4] == ($past(exec_i.sector_missing)
            && $past(exec_i.track_mismatch)))
        else $error("byte 2 wrong track wrong");

    a_crc_location: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> st2_reg[5] == ($past(exec_i.crc_err)
            && $past(exec_i.crc_in_data)))
        else $error("byte 2 crc location wrong");

    a_control_mark: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> st2_reg[6] == $past(exec_i.control_mark))
        else $error("byte 2 control mark wrong");

    a_st3_protect: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        rd_take && set_reg == FRS_SET_ST3
        |=> rd_data_o[6] == !$past(write_prot_b_i))
        else $error("byte 3 write protect wrong");

    a_st3_track_zero: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        rd_take && set_reg == FRS_SET_ST3
        |=> rd_data_o[4] == $past(track_zero_line_i))
        else $error("byte 3 track zero wrong");

    a_byte0_read: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        rd_take && (set_reg == FRS_SET_ST0
            || set_reg == FRS_SET_ST012 && idx_reg == 2'h0)
        |=> rd_data_o == $past(st0_reg))
        else $error("byte 0 read wrong");

    a_byte1_read: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        rd_take && set_reg == FRS_SET_ST012 && idx_reg == 2'h1
        |=> rd_data_o == $past(st1_reg))
        else $error("byte 1 read wrong");

    a_byte2_read: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        rd_take && set_reg == FRS_SET_ST012 && idx_reg == 2'h2
        |=> rd_data_o == $past(st2_reg))
        else $error("byte 2 read wrong");

    a_phase_start: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        start
        |=> result_phase_o && idx_reg == 2'h0)
        else $error("result phase did not start");

    a_phase_hold: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        !start && !rd_take
        |=> $stable(result_phase_o))
        else $error("result phase moved without cause");

    a_done_source: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        result_done_o
        |-> $past(rd_take) && $past(last_byt))
        else $error("done without last byte read");

endmodule : frs_result_status

// ---- tb/frs_host_model.sv ----
// host model: reads result bytes through the data register
`timescale 1ns/10ps
module frs_host_model (
    // clock
    input  wire logic  core_clk_i,
    // control
    input  wire logic  phase_i,
    input  wire logic  slow_i,
    input  wire logic  stray_i,
    // read port
    output logic [2:0] addr_o,
    output logic       rd_o
);
    logic tog_reg = 1'b0;
    wire  want    = phase_i & (~slow_i | tog_reg);

    initial begin
        rd_o   = 1'b0;
        addr_o = 3'h5;
    end

    // slow mode idles every other cycle; stray reads fill the gaps
    always @(negedge core_clk_i) begin
        tog_reg <= ~tog_reg;
        rd_o    <= want | stray_i;
        addr_o  <= (phase_i & ~want) ? 3'h4 : 3'h5;
    end
endmodule // frs_host_model

// ---- tb/frs_result_status_bench.sv ----
// bench: random outcomes, result sets read back and scored
`timescale 1ns/10ps
module frs_result_status_bench
    import frs_pkg::*;
;
    logic       core_clk_i = 0, rst_b_i = 0, cmd_end_i = 0, exec_end_i = 0;
    logic       track_zero_line = 0, wp_b = 1, slow = 0, stray = 0, taken = 0, hit = 0;
    frs_sel_t   cmd_sel = '0, exec_sel = '0;
    frs_exec_t  exec = '0;
    frs_set_t   set = FRS_SET_NONE;
    logic [2:0] addr;
    logic [7:0] rd_data, q[$];
    logic       rd, phase, done;
    logic [31:0] seed = 32'hf1e65670;
    int         mismatches = 0, samples_checked = 0, dones = 0;

    always #20 core_clk_i = ~core_clk_i;

    frs_result_status u_dut (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .rd_i(rd),
        .cmd_end_i(cmd_end_i), .cmd_sel_i(cmd_sel), .exec_end_i(exec_end_i),
        .exec_sel_i(exec_sel), .exec_i(exec), .set_i(set),
        .track_zero_line_i(track_zero_line), .write_prot_b_i(wp_b), .rd_data_o(rd_data),
        .result_phase_o(phase), .result_done_o(done));

    frs_host_model u_host (
        .core_clk_i(core_clk_i), .phase_i(phase), .slow_i(slow),
        .stray_i(stray), .addr_o(addr), .rd_o(rd));

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        for (int i = 0; i < 32; i++) seed = {seed[30:0], ^(seed & 32'h80200003)};
        return seed;
    endfunction

    function automatic logic [31:0] expect_bytes(input frs_exec_t e);
        logic bad;
        bad = e.sector_missing & (e.found_track == FRS_BAD_TRACK_NUM)
            & (e.cmd_track != FRS_BAD_TRACK_NUM);
        return {1'b0, ~wp_b, 1'b1, track_zero_line, 1'b1,
            cmd_sel.head, cmd_sel.drive,
            1'b0, e.control_mark, e.crc_err & e.crc_in_data,
            e.sector_missing & e.track_mismatch,
            e.scan_cmd & e.scan_hit,
            e.scan_cmd & e.scan_fail, bad, e.no_addr_mark & e.mark_in_data,
            e.eot_no_tc, 1'b0, e.crc_err, e.late_service, 1'b0,
            e.sector_missing, e.write_cmd & ~wp_b, e.no_addr_mark,
            e.cause, e.seek_end, e.recal & ~e.track0_seen,
            1'b0, exec_sel.head, exec_sel.drive};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // watcher: every read answers one cycle later
    always @(posedge core_clk_i) begin
        taken <= rd;
        hit   <= rd & (addr == FRS_DATA_OFS) & phase;
    end

    always @(negedge core_clk_i) begin
        if (done === 1'b1) dones++;
        if (taken === 1'b1) begin
            if (hit === 1'b1 && q.size() > 0) chk(rd_data, q.pop_front());
            else chk(rd_data, 8'h00);
        end
    end

    initial begin
        #160000;
        mismatches++;
        conclude();
    end

    initial begin
        logic [31:0] r, b;
        frs_exec_t   e;
        int          d0;
        repeat (12) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        @(negedge core_clk_i);
        chk(rd_data, 8'h00);
        chk({6'h0, phase, done}, 8'h00);
        for (int i = 0; i < 32; i++) begin
            r         = rnd();
            stray     = i[3];
            slow      = i[2];
            track_zero_line      = r[0];
            wp_b      = r[1];
            cmd_sel   = frs_sel_t'(r[4:2]);
            cmd_end_i = 1'b1;
            @(negedge core_clk_i);
            e = frs_exec_t'({rnd(), r[31:30]});
            e.cause = i[1:0];
            if (r[5]) e.found_track = FRS_BAD_TRACK_NUM;
            cmd_end_i  = 1'b0;
            exec       = e;
            exec_sel   = frs_sel_t'(r[10:8]);
            set        = frs_set_t'(i[1:0] + i[3:2]);
            exec_end_i = 1'b1;
            b = expect_bytes(e);
            case (set)
                FRS_SET_ST0:   q.push_back(b[7:0]);
                FRS_SET_ST012: q = {b[7:0], b[15:8], b[23:16]};
                FRS_SET_ST3:   q.push_back(b[31:24]);
                default:       q.delete();
            endcase
            d0 = dones;
            @(negedge core_clk_i);
            exec_end_i = 1'b0;
            for (int k = 0; k < 16 && dones == d0; k++) begin
                @(negedge core_clk_i);
                #1;
            end
            chk({7'h0, phase}, 8'h00);
            chk(8'(q.size()), 8'h00);
            chk(8'(dones - d0), {7'h0, set != FRS_SET_NONE});
            $display("test %0d set %0d ended", i, set);
        end
        conclude();
    end
endmodule // frs_result_status_bench
